// file: core/rail_limits_config_regs.sv
// Per-rail limits, capability and startup-voltage register bank.
// Assumes both host ports deliver one-cycle strobes synchronous to clk.
// Overview of operation
// - 8-bit limit; alarm when temperature reaches it
// - Limit resets to resistor value or 110
// - Loadline, tolerance, current offset read zero
// - Fast slew capability reads constant 13
// - Slow slew capability reads constant 3
// - Startup voltage resets zero; serial bus read-only
// - Startup voltage uses voltage-code table coding
// - Trim is 6-bit sign-magnitude, reserved bits
`timescale 1ns/100ps
module rail_limits_config_regs
  import rail_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Limit resistor strap, sampled after reset release
  input wire logic temperature_limit_resistor_valid,
  input wire logic [7:0] temperature_limit_resistor,
  // SMBus register port
  input wire logic smbus_write,
  input wire logic smbus_read,
  input wire logic [7:0] smbus_address,
  input wire logic [7:0] smbus_write_data,
  output logic [7:0] smbus_read_data,
  // Serial voltage id bus register port
  input wire logic serial_voltage_id_bus_write,
  input wire logic serial_voltage_id_bus_read,
  input wire logic [7:0] serial_voltage_id_bus_address,
  input wire logic [7:0] serial_voltage_id_bus_write_data,
  output logic [7:0] serial_voltage_id_bus_read_data,
  // Measured rail temperatures
  input wire logic [7:0] rail1_temperature,
  input wire logic [7:0] rail2_temperature,
  // Block outputs
  output logic [7:0] rail1_adjusted_temperature,
  output logic [7:0] rail2_adjusted_temperature,
  output logic overheat_alarm,
  output logic [7:0] rail1_startup_code,
  output logic [7:0] rail2_startup_code
);
  logic [7:0] rail2_temperature_limit;
  logic [7:0] rail1_startup_voltage;
  logic [7:0] rail2_startup_voltage;
  logic [7:0] rail1_temperature_trim;
  logic [7:0] rail2_temperature_trim;
  logic strap_pending;
  logic [7:0] smbus_view;
  logic [7:0] serial_view;
  logic limit_write;
  logic startup1_write;
  logic startup2_write;
  logic trim1_write;
  logic trim2_write;

  temp_adjust_if rail1_link ();
  temp_adjust_if rail2_link ();

  // Rail 1 limit lives outside this bank; alarm only uses rail 2 here
  // Rail 1 alarm is computed but left unread at this level
  assign rail1_link.raw_temperature = rail1_temperature;
  assign rail1_link.trim = rail1_temperature_trim;
  assign rail1_link.limit = 8'hFF;
  assign rail2_link.raw_temperature = rail2_temperature;
  assign rail2_link.trim = rail2_temperature_trim;
  assign rail2_link.limit = rail2_temperature_limit;

  rail_temp_adjust rail1_adjust (
    .clk(clk),
    .rstn(rstn),
    .port(rail1_link.adjust)
  );

  rail_temp_adjust rail2_adjust (
    .clk(clk),
    .rstn(rstn),
    .port(rail2_link.adjust)
  );

  assign rail1_adjusted_temperature = rail1_link.adjusted_temperature;
  assign rail2_adjusted_temperature = rail2_link.adjusted_temperature;
  assign overheat_alarm = rail2_link.alarm;

  // Catch the strap once, one cycle after reset release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_pending <= 1'b1;
    end else begin
      strap_pending <= 1'b0;
    end
  end

  // SMBus write decode; read-only and unmapped addresses select nothing
  always_comb begin
    limit_write = 1'b0;
    startup1_write = 1'b0;
    startup2_write = 1'b0;
    trim1_write = 1'b0;
    trim2_write = 1'b0;
    if (smbus_address == ADDR_RAIL2_TEMPERATURE_LIMIT) begin
      limit_write = smbus_write;
    end else if (smbus_address == ADDR_RAIL1_STARTUP_VOLTAGE) begin
      startup1_write = smbus_write;
    end else if (smbus_address == ADDR_RAIL2_STARTUP_VOLTAGE) begin
      startup2_write = smbus_write;
    end else if (smbus_address == ADDR_RAIL1_TEMPERATURE_TRIM) begin
      trim1_write = smbus_write;
    end else if (smbus_address == ADDR_RAIL2_TEMPERATURE_TRIM) begin
      trim2_write = smbus_write;
    end
  end

  // Temperature limit: default, then strap, then SMBus overwrites
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rail2_temperature_limit <= RESET_TEMPERATURE_LIMIT;
    end else if (limit_write) begin
      rail2_temperature_limit <= smbus_write_data;
    end else if (strap_pending && temperature_limit_resistor_valid) begin
      rail2_temperature_limit <= temperature_limit_resistor;
    end
  end

  // Rail 1 startup voltage; serial writes never reach it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rail1_startup_voltage <= RESET_STARTUP_VOLTAGE;
    end else if (startup1_write) begin
      rail1_startup_voltage <= smbus_write_data;
    end
  end

  // Rail 2 startup voltage, same rules as rail 1
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rail2_startup_voltage <= RESET_STARTUP_VOLTAGE;
    end else if (startup2_write) begin
      rail2_startup_voltage <= smbus_write_data;
    end
  end

  // Codes pass straight through in voltage-code table form
  assign rail1_startup_code = rail1_startup_voltage;
  assign rail2_startup_code = rail2_startup_voltage;

  // Rail 1 trim: reserved bits 7:6 kept read/write, reset to zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rail1_temperature_trim <= RESET_TEMPERATURE_TRIM;
    end else if (trim1_write) begin
      rail1_temperature_trim <= smbus_write_data & TRIM_WRITE_MASK;
    end
  end

  // Rail 2 trim, same layout as rail 1
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rail2_temperature_trim <= RESET_TEMPERATURE_TRIM;
    end else if (trim2_write) begin
      rail2_temperature_trim <= smbus_write_data & TRIM_WRITE_MASK;
    end
  end

  // Common read decode; unmapped addresses return zero
  function automatic logic [7:0] read_view(input logic [7:0] addr);
    logic [7:0] value;
    value = VALUE_UNMAPPED;
    if (addr == ADDR_RAIL2_TEMPERATURE_LIMIT) begin
      value = rail2_temperature_limit;
    end else if (addr == ADDR_RAIL1_LOADLINE ||
                 addr == ADDR_RAIL2_LOADLINE ||
                 addr == ADDR_RAIL1_TOLERANCE ||
                 addr == ADDR_RAIL2_TOLERANCE ||
                 addr == ADDR_RAIL1_CURRENT_OFFSET ||
                 addr == ADDR_RAIL2_CURRENT_OFFSET) begin
      value = VALUE_UNSUPPORTED;
    end else if (addr == ADDR_RAIL1_FAST_SLEW ||
                 addr == ADDR_RAIL2_FAST_SLEW) begin
      value = VALUE_FAST_SLEW;
    end else if (addr == ADDR_RAIL1_SLOW_SLEW ||
                 addr == ADDR_RAIL2_SLOW_SLEW) begin
      value = VALUE_SLOW_SLEW;
    end else if (addr == ADDR_RAIL1_STARTUP_VOLTAGE) begin
      value = rail1_startup_voltage;
    end else if (addr == ADDR_RAIL2_STARTUP_VOLTAGE) begin
      value = rail2_startup_voltage;
    end else if (addr == ADDR_RAIL1_TEMPERATURE_TRIM) begin
      value = rail1_temperature_trim;
    end else if (addr == ADDR_RAIL2_TEMPERATURE_TRIM) begin
      value = rail2_temperature_trim;
    end
    return value;
  endfunction

  // Read views; always_comb also follows registers read in the function
  always_comb begin
    smbus_view = read_view(smbus_address);
  end

  always_comb begin
    serial_view = read_view(serial_voltage_id_bus_address);
  end

  // Read data held until the next read on the same port
  always_ff @(posedge clk) begin
    if (!rstn) begin
      smbus_read_data <= 8'h00;
    end else if (smbus_read) begin
      smbus_read_data <= smbus_view;
    end
  end

  // Serial bus sees all registers read-only
  // Its write strobe and data are never decoded, so writes vanish
  always_ff @(posedge clk) begin
    if (!rstn) begin
      serial_voltage_id_bus_read_data <= 8'h00;
    end else if (serial_voltage_id_bus_read) begin
      serial_voltage_id_bus_read_data <= serial_view;
    end
  end
endmodule

// file: core/rail_regs_pkg.sv
// Register map, reset values and field layout of the rail limits bank.
// Shared by the bank and its per-rail temperature adjust module.
package rail_regs_pkg;
  localparam logic [7:0] ADDR_RAIL2_TEMPERATURE_LIMIT = 8'hCB;
  localparam logic [7:0] ADDR_RAIL1_LOADLINE = 8'hCC;
  localparam logic [7:0] ADDR_RAIL2_LOADLINE = 8'hCD;
  localparam logic [7:0] ADDR_RAIL1_FAST_SLEW = 8'hCE;
  localparam logic [7:0] ADDR_RAIL2_FAST_SLEW = 8'hCF;
  localparam logic [7:0] ADDR_RAIL1_SLOW_SLEW = 8'hD0;
  localparam logic [7:0] ADDR_RAIL2_SLOW_SLEW = 8'hD1;
  localparam logic [7:0] ADDR_RAIL1_STARTUP_VOLTAGE = 8'hD2;
  localparam logic [7:0] ADDR_RAIL2_STARTUP_VOLTAGE = 8'hD3;
  localparam logic [7:0] ADDR_RAIL1_TOLERANCE = 8'hD4;
  localparam logic [7:0] ADDR_RAIL2_TOLERANCE = 8'hD5;
  localparam logic [7:0] ADDR_RAIL1_CURRENT_OFFSET = 8'hD6;
  localparam logic [7:0] ADDR_RAIL2_CURRENT_OFFSET = 8'hD7;
  localparam logic [7:0] ADDR_RAIL1_TEMPERATURE_TRIM = 8'hD8;
  localparam logic [7:0] ADDR_RAIL2_TEMPERATURE_TRIM = 8'hD9;

  localparam logic [7:0] RESET_TEMPERATURE_LIMIT = 8'h6E;
  localparam logic [7:0] RESET_STARTUP_VOLTAGE = 8'h00;
  localparam logic [7:0] RESET_TEMPERATURE_TRIM = 8'h00;
  localparam logic [7:0] VALUE_UNSUPPORTED = 8'h00;
  localparam logic [7:0] VALUE_FAST_SLEW = 8'h0D;
  localparam logic [7:0] VALUE_SLOW_SLEW = 8'h03;
  localparam logic [7:0] VALUE_UNMAPPED = 8'h00;
  // Voltage code for 1.0 V, same coding as the voltage-code table
  localparam logic [7:0] VOLTAGE_CODE_1V0 = 8'h97;

  localparam int TRIM_SIGN_BIT = 5;
  localparam int TRIM_MAG_MSB = 4;
  localparam int TRIM_WIDTH = 6;
  localparam logic [7:0] TRIM_WRITE_MASK = 8'hFF;
endpackage

// file: core/temp_adjust_if.sv
// Carrier between the bank and one rail's temperature adjust module.
// Assumes one clock; all signals are plain levels.
`timescale 1ns/100ps
interface temp_adjust_if;
  logic [7:0] raw_temperature;
  logic [7:0] trim;
  logic [7:0] limit;
  logic [7:0] adjusted_temperature;
  logic alarm;
  modport bank (output raw_temperature, output trim, output limit,
    input adjusted_temperature, input alarm);
  modport adjust (input raw_temperature, input trim, input limit,
    output adjusted_temperature, output alarm);
endinterface

// file: core/rail_temp_adjust.sv
// Applies one rail's sign-magnitude trim and compares against the limit.
// Assumes temperatures are synchronous to clk; outputs are registered.
`timescale 1ns/100ps
module rail_temp_adjust
  import rail_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bank side
  temp_adjust_if.adjust port
);
  logic [9:0] sum;
  logic [7:0] next_adjusted;
  logic [4:0] magnitude;

  // Signed add, saturated to 0..255 so a wrap cannot hide a hot rail
  always_comb begin
    magnitude = port.trim[TRIM_MAG_MSB:0];
    if (port.trim[TRIM_SIGN_BIT]) begin
      sum = {2'b00, port.raw_temperature} - {5'h00, magnitude};
    end else begin
      sum = {2'b00, port.raw_temperature} + {5'h00, magnitude};
    end
    if (sum[9]) begin
      next_adjusted = 8'h00;
    end else if (sum[8]) begin
      next_adjusted = 8'hFF;
    end else begin
      next_adjusted = sum[7:0];
    end
  end

  // Adjusted reading and alarm at or above the limit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      port.adjusted_temperature <= 8'h00;
      port.alarm <= 1'b0;
    end else begin
      port.adjusted_temperature <= next_adjusted;
      port.alarm <= (next_adjusted >= port.limit);
    end
  end
endmodule

// file: dv/rail_limits_config_regs_asserts.sv
// Port checker for the rail limits bank.
// Assumes it is bound into rail_limits_config_regs by the testbench.
`timescale 1ns/100ps
module rail_regs_check (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register ports
  input wire logic smbus_write,
  input wire logic smbus_read,
  input wire logic [7:0] smbus_address,
  input wire logic [7:0] smbus_read_data,
  input wire logic serial_voltage_id_bus_write,
  // Startup outputs
  input wire logic [7:0] rail1_startup_code,
  input wire logic [7:0] rail2_startup_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Plain read; a write in the same cycle would change the result
  sequence sm_rd(logic [7:0] a);
    smbus_read && !smbus_write && smbus_address == a;
  endsequence
  fast_slew_a: assert property (
    sm_rd(8'hCE) |=> smbus_read_data == 8'h0D)
    else $error("fast slew read wrong");
  fast_slew2_a: assert property (
    sm_rd(8'hCF) |=> smbus_read_data == 8'h0D)
    else $error("rail2 fast slew read wrong");
  slow_slew_a: assert property (
    sm_rd(8'hD1) |=> smbus_read_data == 8'h03)
    else $error("slow slew read wrong");
  loadline_zero_a: assert property (
    sm_rd(8'hCC) |=> smbus_read_data == 8'h00)
    else $error("loadline read not zero");
  startup_one_a: assert property (
    sm_rd(8'hD2) |=> smbus_read_data == rail1_startup_code)
    else $error("startup read differs from output");
  startup_two_a: assert property (
    sm_rd(8'hD3) |=> smbus_read_data == rail2_startup_code)
    else $error("rail2 startup read differs");
  serial_ignored_a: assert property (
    serial_voltage_id_bus_write && !smbus_write
    |=> $stable(rail1_startup_code) && $stable(rail2_startup_code))
    else $error("serial write changed startup");
  startup_reset_a: assert property (disable iff (1'b0) !rstn
    |=> rail1_startup_code == 8'h00 && rail2_startup_code == 8'h00)
    else $error("startup not cleared by reset");
endmodule

// file: dv/reg_host_model.sv
// Host model for the SMBus and serial register ports.
// Assumes strobes are taken at the rising edge after they rise.
`timescale 1ns/100ps
module reg_host_model (
  // Clock
  input wire logic clk,
  // SMBus port
  output logic sw,
  output logic sr,
  output logic [7:0] sa,
  output logic [7:0] sd,
  input wire logic [7:0] sq,
  // Serial port
  output logic vw,
  output logic vr,
  output logic [7:0] va,
  output logic [7:0] vd,
  input wire logic [7:0] vq
);
  initial {sw, sr, sa, sd, vw, vr, va, vd} = 36'h0;
  // One access; idle lines invert so stale values never match
  task automatic access(input logic ser, input logic wr,
    input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    if (ser) {vw, vr, va, vd} = {wr, !wr, a, d};
    else {sw, sr, sa, sd} = {wr, !wr, a, d};
    @(negedge clk);
    q = ser ? vq : sq;
    {sw, sr, sa, sd, vw, vr, va, vd} = {2'h0, ~a, ~d, 2'h0, ~a, ~d};
  endtask
endmodule

// file: dv/tb_rail_limits_config_regs.sv
// Testbench for the rail limits bank: defaults, writes, trim, strap.
// Assumes the host model drives both register ports at falling edges.
`timescale 1ns/100ps
module tb_rail_limits_config_regs;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic strap_valid = 1'b0;
  logic [7:0] strap_value = 8'h50;
  logic [7:0] t1 = 8'h10;
  logic [7:0] t2 = 8'h00;
  logic sw, sr, vw, vr, alarm;
  logic [7:0] sa, sd, sq, va, vd, vq, adj1, adj2, code1, code2;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  reg_host_model host (.clk(clk), .sw(sw), .sr(sr), .sa(sa), .sd(sd),
    .sq(sq), .vw(vw), .vr(vr), .va(va), .vd(vd), .vq(vq));
  rail_limits_config_regs dut (.clk(clk), .rstn(rstn),
    .temperature_limit_resistor_valid(strap_valid),
    .temperature_limit_resistor(strap_value), .smbus_write(sw),
    .smbus_read(sr), .smbus_address(sa), .smbus_write_data(sd),
    .smbus_read_data(sq), .serial_voltage_id_bus_write(vw),
    .serial_voltage_id_bus_read(vr), .serial_voltage_id_bus_address(va),
    .serial_voltage_id_bus_write_data(vd),
    .serial_voltage_id_bus_read_data(vq), .rail1_temperature(t1),
    .rail2_temperature(t2), .rail1_adjusted_temperature(adj1),
    .rail2_adjusted_temperature(adj2), .overheat_alarm(alarm),
    .rail1_startup_code(code1), .rail2_startup_code(code2));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.access(s, 1'b0, a, 8'h00, q);
    check(q, e);
  endtask
  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.access(s, 1'b1, a, d, q);
  endtask
  // Every register at reset, both ports, plus an unmapped address
  task automatic t_defaults;
    logic [7:0] e;
    for (logic [7:0] a = 8'hCB; a <= 8'hD9; a++) begin
      e = a == 8'hCB ? 8'h6E : a inside {8'hCE, 8'hCF} ? 8'h0D :
        a inside {8'hD0, 8'hD1} ? 8'h03 : 8'h00;
      rd(1'b0, a, e);
      rd(1'b1, a, e);
    end
    rd(1'b0, 8'hE0, 8'h00);
    $display("defaults done");
  endtask
  // SMBus writes land; read-only and serial writes are dropped
  task automatic t_writes;
    wr(1'b0, 8'hCB, 8'h64);
    wr(1'b0, 8'hD2, 8'h97);
    wr(1'b0, 8'hD3, 8'h5A);
    wr(1'b0, 8'hD8, 8'hC5);
    wr(1'b0, 8'hCE, 8'hFF);
    wr(1'b1, 8'hD3, 8'hFF);
    rd(1'b0, 8'hCB, 8'h64);
    rd(1'b1, 8'hD3, 8'h5A);
    rd(1'b0, 8'hD8, 8'hC5);
    rd(1'b0, 8'hCE, 8'h0D);
    check(code1, 8'h97);
    $display("writes done");
  endtask
  // Sign, reserved bits, saturation and the inclusive alarm edge
  task automatic t_trim;
    logic [7:0] t [6][4] = '{'{8'h5F, 8'h04, 8'h63, 8'h00},
      '{8'h5F, 8'h05, 8'h64, 8'h01}, '{8'h5F, 8'h20, 8'h5F, 8'h00},
      '{8'h5F, 8'h3F, 8'h40, 8'h00}, '{8'h10, 8'hFF, 8'h00, 8'h00},
      '{8'hFE, 8'h45, 8'hFF, 8'h01}};
    for (int i = 0; i < 6; i++) begin
      wr(1'b0, 8'hD9, t[i][1]);
      t2 = t[i][0];
      repeat (2) @(negedge clk);
      check(adj2, t[i][2]);
      check({7'h00, alarm}, t[i][3]);
    end
    check(adj1, 8'h15);
    $display("trim done");
  endtask
  // Mid-run reset with the limit strap present
  task automatic t_strap;
    @(negedge clk);
    rstn = 1'b0;
    strap_valid = 1'b1;
    repeat (2) @(negedge clk);
    check(code1, 8'h00);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    strap_valid = 1'b0;
    rd(1'b0, 8'hCB, 8'h50);
    $display("strap done");
  endtask
  task automatic complete_run;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    t_defaults;
    t_writes;
    t_trim;
    t_strap;
    complete_run;
  end
  // Hang guard, far beyond the roughly 120 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      complete_run;
    end
  end
endmodule
bind rail_limits_config_regs rail_regs_check chk (.clk(clk), .rstn(rstn),
  .smbus_write(smbus_write), .smbus_read(smbus_read),
  .smbus_address(smbus_address), .smbus_read_data(smbus_read_data),
  .serial_voltage_id_bus_write(serial_voltage_id_bus_write),
  .rail1_startup_code(rail1_startup_code),
  .rail2_startup_code(rail2_startup_code));
